// >>> hdl/aods_top.sv
// Per-channel output value control: source selection, defaulting, ramping and scaling
`default_nettype none
// What this block does
// - Disabled-current range drives zero milliamps
// - Disabled-voltage range drives zero volts
// - Hold-last keeps value during disable or fault
// - Otherwise fault or disable selects default value
// - Positive default rate ramps to default
// - Three conditions count as faults: outputs off, CPU or I/O comm lost
// - Backplane power loss jumps, never ramps
// - Hot removal while enabled holds all channels
// - Service request module reset holds all
// - First store after power jumps to default
// - Identical first store leaves outputs unchanged
// - Later reconfigurations use default ramp rate
// - Enabled, no rate: output follows command
// - Enabled with rate: ramp to command
// - Default ramp starts from last value
// - Field power loss zeroes every channel
// - Default scaling equals physical units
// - Linear map through two scale pairs
// - Equal scale pairs bypass scaling
// - Alarms judge engineering units value
// - Command is 16-bit integer or 32-bit
// - Default rate zero means no ramp
module aods_top
  import aods_pkg::*;
#(
  parameter int unsigned UPDATE_CYCLES_P = UPDATE_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire aods_pins_t pins_in,
  output var aods_out_t chan_out [NCH]
);
  aods_pins_t sync1_reg;
  aods_pins_t sync2_reg;
  aods_pins_t prev_reg;
  logic [31:0] tick_cnt_reg;
  logic tick;
  logic field_lost;
  logic bp_lost;
  logic fault_mode;
  logic bp_rise;
  logic svc_rise;
  logic hot_rise;
  logic first_pending_reg;
  logic dirty_reg;
  logic reconfig_reg;
  logic first_jump_reg;
  logic first_keep_reg;
  logic svc_hold_reg;
  logic hot_hold_reg;
  logic store_pulse;
  logic cfg_change;
  logic all_settled;
  logic [CH_BITS-1:0] acc_ch;
  logic [3:0] acc_idx;
  logic acc_ok;
  logic [31:0] rd_word;
  logic rd_hit;
  aods_ctrl_t ctrl_view;
  aods_cfg_t cfg_reg [NCH];
  logic signed [31:0] eng_reg [NCH];
  logic signed [31:0] dac_val [NCH];
  logic off_cur_reg [NCH];
  logic off_volt_reg [NCH];
  logic [NCH-1:0] settled;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; prev_reg only delays the second stage for edges
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // Conditions that steer all channels
  assign field_lost = !sync2_reg.field_power_ok;
  assign bp_lost = !sync2_reg.backplane_ok;
  assign fault_mode = !sync2_reg.outputs_enabled || !sync2_reg.cpu_comm_ok || !sync2_reg.io_comm_ok;
  assign bp_rise = sync2_reg.backplane_ok && !prev_reg.backplane_ok;
  assign svc_rise = sync2_reg.service_request_call && !prev_reg.service_request_call;
  assign hot_rise = sync2_reg.hot_removed && !prev_reg.hot_removed;

  // Update period tick; ramps advance only here
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end
  assign tick = (tick_cnt_reg >= 32'(UPDATE_CYCLES_P - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Register access decode
  assign acc_ch = reg_addr[ADDR_CH_LSB +: CH_BITS];
  assign acc_idx = reg_addr[ADDR_IDX_LSB +: 4];
  assign acc_ok = (reg_addr[1:0] == 2'h0);
  assign store_pulse = reg_wr && acc_ok && acc_ch == '0 && acc_idx == IDX_CTRL && reg_wdata[CTRL_STORE_BIT];

  always_comb begin
    ctrl_view = '0;
    ctrl_view.hot_hold = hot_hold_reg;
    ctrl_view.svc_hold = svc_hold_reg;
    ctrl_view.first_pending = first_pending_reg;
    ctrl_view.reconfig = reconfig_reg;
    ctrl_view.dirty = dirty_reg;
  end

  // Read mux; unmapped words read as zero
  always_comb begin
    rd_word = '0;
    rd_hit = acc_ok;
    case (acc_idx)
      IDX_CMD: rd_word = cfg_reg[acc_ch].cmd;
      IDX_CFG: rd_word = {28'h0000000, cfg_reg[acc_ch].fmt_int16, cfg_reg[acc_ch].hold_last,
                          cfg_reg[acc_ch].range_type};
      IDX_DEF_VAL: rd_word = cfg_reg[acc_ch].def_val;
      IDX_DEF_RATE: rd_word = cfg_reg[acc_ch].def_rate;
      IDX_EN_RATE: rd_word = cfg_reg[acc_ch].en_rate;
      IDX_HI_ENG: rd_word = cfg_reg[acc_ch].hi_eng;
      IDX_LO_ENG: rd_word = cfg_reg[acc_ch].lo_eng;
      IDX_HI_DAC: rd_word = cfg_reg[acc_ch].hi_dac;
      IDX_LO_DAC: rd_word = cfg_reg[acc_ch].lo_dac;
      IDX_ENG_OUT: rd_word = eng_reg[acc_ch];
      IDX_DAC_OUT: rd_word = dac_val[acc_ch];
      IDX_CTRL: begin
        rd_word = ctrl_view;
        rd_hit = acc_ok && (acc_ch == '0);
      end
      default: rd_hit = 1'b0;
    endcase
    if (!rd_hit) begin
      rd_word = '0;
    end
  end

  // A configuration write that alters a stored value marks the set as changed
  assign cfg_change = reg_wr && rd_hit && acc_idx >= IDX_CFG && acc_idx <= IDX_LO_DAC &&
                      ((acc_idx == IDX_CFG) ? (reg_wdata[3:0] != rd_word[3:0]) : (reg_wdata != rd_word));

  // Read data stand one cycle only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rd_word;
    end else begin
      reg_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-up store tracking; a power return set wins over a store clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      first_pending_reg <= 1'b1;
    end else if (bp_rise) begin
      first_pending_reg <= 1'b1;
    end else if (store_pulse) begin
      first_pending_reg <= 1'b0;
    end
  end

  // Changed-configuration flag, cleared by a store unless a change lands with it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dirty_reg <= 1'b0;
    end else if (cfg_change) begin
      dirty_reg <= 1'b1;
    end else if (store_pulse) begin
      dirty_reg <= 1'b0;
    end
  end

  // Reconfiguration window ends when every ramping channel has arrived
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reconfig_reg <= 1'b0;
      first_jump_reg <= 1'b0;
      first_keep_reg <= 1'b0;
    end else if (store_pulse) begin
      reconfig_reg <= 1'b1;
      first_jump_reg <= first_pending_reg && dirty_reg;
      first_keep_reg <= first_pending_reg && !dirty_reg;
    end else if (reconfig_reg && all_settled) begin
      reconfig_reg <= 1'b0;
      first_jump_reg <= 1'b0;
      first_keep_reg <= 1'b0;
    end
  end

  // Module reset by service request: hold until the next store
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      svc_hold_reg <= 1'b0;
    end else if (svc_rise) begin
      svc_hold_reg <= 1'b1;
    end else if (store_pulse) begin
      svc_hold_reg <= 1'b0;
    end
  end

  // Hot removal counts only if outputs were enabled when it began
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hot_hold_reg <= 1'b0;
    end else if (hot_rise && sync2_reg.outputs_enabled) begin
      hot_hold_reg <= 1'b1;
    end else if (!sync2_reg.hot_removed) begin
      hot_hold_reg <= 1'b0;
    end
  end

  assign all_settled = &settled;

  ////////////////////////////////////////////////////////////////////////////
  // Channels
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    aods_sel_t sel;
    logic signed [31:0] tgt;
    logic signed [31:0] rate;
    logic signed [31:0] cmd_q;
    logic signed [31:0] step_next;

    // Configuration and command words
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        cfg_reg[g] <= CFG_RST;
      end else if (reg_wr && acc_ok && acc_ch == CH_BITS'(g)) begin
        case (acc_idx)
          IDX_CMD: cfg_reg[g].cmd <= reg_wdata;
          IDX_CFG: begin
            cfg_reg[g].range_type <= aods_range_t'(reg_wdata[CFG_RANGE_LSB +: 2]);
            cfg_reg[g].hold_last <= reg_wdata[CFG_HOLD_BIT];
            cfg_reg[g].fmt_int16 <= reg_wdata[CFG_FMT_BIT];
          end
          IDX_DEF_VAL: cfg_reg[g].def_val <= reg_wdata;
          IDX_DEF_RATE: cfg_reg[g].def_rate <= reg_wdata;
          IDX_EN_RATE: cfg_reg[g].en_rate <= reg_wdata;
          IDX_HI_ENG: cfg_reg[g].hi_eng <= reg_wdata;
          IDX_LO_ENG: cfg_reg[g].lo_eng <= reg_wdata;
          IDX_HI_DAC: cfg_reg[g].hi_dac <= reg_wdata;
          IDX_LO_DAC: cfg_reg[g].lo_dac <= reg_wdata;
          default: ;
        endcase
      end
    end

    // Integer commands become whole Q16.16 values
    assign cmd_q = cfg_reg[g].fmt_int16 ? {cfg_reg[g].cmd[15:0], 16'h0000} : cfg_reg[g].cmd;

    // Source selection in fixed priority
    always_comb begin
      sel = SEL_HOLD;
      tgt = eng_reg[g];
      rate = '0;
      if (field_lost || cfg_reg[g].range_type != RT_CUR_VOLT) begin
        sel = SEL_ZERO;
        tgt = ZERO_VAL;
      end else if (hot_hold_reg || svc_hold_reg) begin
        sel = SEL_HOLD;
      end else if (bp_lost) begin
        if (!cfg_reg[g].hold_last) begin
          sel = SEL_JUMP;
          tgt = cfg_reg[g].def_val;
        end
      end else if (fault_mode || reconfig_reg) begin
        if (first_keep_reg || cfg_reg[g].hold_last) begin
          sel = SEL_HOLD;
        end else if (first_jump_reg || cfg_reg[g].def_rate <= 0) begin
          sel = SEL_JUMP;
          tgt = cfg_reg[g].def_val;
        end else begin
          sel = SEL_RAMP;
          tgt = cfg_reg[g].def_val;
          rate = cfg_reg[g].def_rate;
        end
      end else if (cfg_reg[g].en_rate <= 0) begin
        sel = SEL_JUMP;
        tgt = cmd_q;
      end else begin
        sel = SEL_RAMP;
        tgt = cmd_q;
        rate = cfg_reg[g].en_rate;
      end
    end

    assign settled[g] = (sel != SEL_RAMP) || (eng_reg[g] == tgt);

    aods_ramp_step u_ramp (
      .cur(eng_reg[g]),
      .target(tgt),
      .step(rate),
      .next_val(step_next)
    );

    // Engineering-unit output value; ramps start from the present value
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        eng_reg[g] <= ZERO_VAL;
      end else begin
        case (sel)
          SEL_ZERO: eng_reg[g] <= ZERO_VAL;
          SEL_JUMP: eng_reg[g] <= tgt;
          SEL_RAMP: begin
            if (tick) begin
              eng_reg[g] <= step_next;
            end
          end
          default: ;
        endcase
      end
    end

    // Drive-off flags; disabled ranges ignore all other settings
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        off_cur_reg[g] <= 1'b1;
        off_volt_reg[g] <= 1'b1;
      end else begin
        off_cur_reg[g] <= field_lost || cfg_reg[g].range_type != RT_CUR_VOLT;
        off_volt_reg[g] <= field_lost || cfg_reg[g].range_type != RT_CUR_VOLT;
      end
    end

    aods_scaler u_scale (
      .clk(clk),
      .arst_n(arst_n),
      .eng(eng_reg[g]),
      .hi_eng(cfg_reg[g].hi_eng),
      .lo_eng(cfg_reg[g].lo_eng),
      .hi_dac(cfg_reg[g].hi_dac),
      .lo_dac(cfg_reg[g].lo_dac),
      .force_zero(off_cur_reg[g]),
      .dac_reg(dac_val[g])
    );

    // Alarm logic outside judges the eng field, not the converter value
    assign chan_out[g] = '{eng: eng_reg[g], dac: dac_val[g],
                           off_current: off_cur_reg[g], off_voltage: off_volt_reg[g]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on channel 0 and the shared control state
  logic signed [31:0] ch0_eng;
  logic signed [31:0] ch0_tgt;
  logic signed [31:0] ch0_cmd;
  logic signed [31:0] ch0_def;
  logic ch0_live;
  assign ch0_eng = eng_reg[0];
  assign ch0_tgt = g_ch[0].tgt;
  assign ch0_cmd = g_ch[0].cmd_q;
  assign ch0_def = cfg_reg[0].def_val;
  assign ch0_live = !field_lost && cfg_reg[0].range_type == RT_CUR_VOLT;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_first_dirty_store;
    store_pulse && first_pending_reg && dirty_reg;
  endsequence
  sequence s_first_clean_store;
    store_pulse && first_pending_reg && !dirty_reg;
  endsequence
  sequence s_ramp_up;
    tick && g_ch[0].sel == SEL_RAMP && ch0_tgt >= ch0_eng;
  endsequence

  a_field_zero: assert property (field_lost |=> ch0_eng == 0 && off_cur_reg[0] && off_volt_reg[0])
    else $error("field power loss did not zero the channel");
  a_disabled_current: assert property (cfg_reg[0].range_type == RT_DIS_CURR |=> ch0_eng == 0 && off_cur_reg[0])
    else $error("disabled current channel still driven");
  a_disabled_voltage: assert property (cfg_reg[0].range_type == RT_DIS_VOLT |=> ch0_eng == 0 && off_volt_reg[0])
    else $error("disabled voltage channel still driven");
  a_service_hold: assert property (svc_hold_reg && ch0_live |=> ch0_eng == $past(ch0_eng))
    else $error("channel moved during service request hold");
  a_hot_hold: assert property (hot_hold_reg && ch0_live |=> ch0_eng == $past(ch0_eng))
    else $error("channel moved during hot removal");
  a_backplane_jump: assert property (ch0_live && bp_lost && !hot_hold_reg && !svc_hold_reg && !cfg_reg[0].hold_last
    |=> ch0_eng == $past(ch0_def))
    else $error("backplane loss did not jump to default");
  a_fault_hold: assert property (ch0_live && !bp_lost && !hot_hold_reg && !svc_hold_reg && fault_mode &&
    cfg_reg[0].hold_last |=> ch0_eng == $past(ch0_eng))
    else $error("hold last state not kept in fault");
  a_direct_cmd: assert property (ch0_live && !bp_lost && !fault_mode && !reconfig_reg && !hot_hold_reg &&
    !svc_hold_reg && cfg_reg[0].en_rate == 0 |=> ch0_eng == $past(ch0_cmd))
    else $error("enabled channel did not follow command");
  a_ramp_bound: assert property (s_ramp_up |=> ch0_eng <= $past(ch0_tgt) && ch0_eng >= $past(ch0_eng))
    else $error("ramp step overshot or went backward");
  a_first_jump: assert property (s_first_dirty_store |=> first_jump_reg && reconfig_reg && !first_pending_reg)
    else $error("first store did not select immediate default");
  a_first_keep: assert property (s_first_clean_store |=> first_keep_reg && !first_jump_reg)
    else $error("identical first store did not keep outputs");
  a_later_store: assert property (store_pulse && !first_pending_reg && !bp_rise
    |=> reconfig_reg && !first_jump_reg && !first_keep_reg)
    else $error("later store skipped the default ramp");
  a_rd_unmapped: assert property (reg_rd && !rd_hit |=> reg_rdata == 0)
    else $error("unmapped read returned nonzero data");
endmodule // aods_top
`default_nettype wire

// >>> hdl/aods_pkg.sv
// Shared constants, register map and types of the analog output default and scaling block
`default_nettype none
package aods_pkg;
  // Geometry
  localparam int NCH = 4;
  localparam int CH_BITS = 2;
  // Timing: output update period, in microseconds, and its count of clock cycles
  localparam int CLK_PERIOD_NS = 5;
  localparam int UPDATE_PERIOD_US = 1000;
  localparam int UPDATE_CYCLES = (UPDATE_PERIOD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Byte address layout: {channel, word index, 2'b00}
  localparam int ADDR_IDX_LSB = 2;
  localparam int ADDR_CH_LSB = 6;
  localparam logic [3:0] IDX_CMD = 4'h0;
  localparam logic [3:0] IDX_CFG = 4'h1;
  localparam logic [3:0] IDX_DEF_VAL = 4'h2;
  localparam logic [3:0] IDX_DEF_RATE = 4'h3;
  localparam logic [3:0] IDX_EN_RATE = 4'h4;
  localparam logic [3:0] IDX_HI_ENG = 4'h5;
  localparam logic [3:0] IDX_LO_ENG = 4'h6;
  localparam logic [3:0] IDX_HI_DAC = 4'h7;
  localparam logic [3:0] IDX_LO_DAC = 4'h8;
  localparam logic [3:0] IDX_ENG_OUT = 4'h9;
  localparam logic [3:0] IDX_DAC_OUT = 4'ha;
  localparam logic [3:0] IDX_CTRL = 4'hf;
  // Field positions
  localparam int CFG_RANGE_LSB = 0;
  localparam int CFG_HOLD_BIT = 2;
  localparam int CFG_FMT_BIT = 3;
  localparam int CTRL_STORE_BIT = 0;
  // Values in signed Q16.16 engineering or converter units
  localparam logic [31:0] ZERO_VAL = 32'h0000_0000;
  localparam logic [31:0] SCALE_HI_RST = 32'h000a_0000;
  localparam logic [31:0] SCALE_LO_RST = 32'hfff6_0000;

  typedef enum logic [1:0] {RT_DIS_VOLT, RT_DIS_CURR, RT_CUR_VOLT} aods_range_t;
  typedef enum logic [1:0] {SEL_ZERO, SEL_HOLD, SEL_JUMP, SEL_RAMP} aods_sel_t;

  typedef struct packed {
    aods_range_t range_type;
    logic hold_last;
    logic fmt_int16;
    logic signed [31:0] cmd;
    logic signed [31:0] def_val;
    logic signed [31:0] def_rate;
    logic signed [31:0] en_rate;
    logic signed [31:0] hi_eng;
    logic signed [31:0] lo_eng;
    logic signed [31:0] hi_dac;
    logic signed [31:0] lo_dac;
  } aods_cfg_t;

  localparam aods_cfg_t CFG_RST = '{range_type: RT_DIS_CURR, hold_last: 1'b0, fmt_int16: 1'b0,
    cmd: ZERO_VAL, def_val: ZERO_VAL, def_rate: ZERO_VAL, en_rate: ZERO_VAL,
    hi_eng: SCALE_HI_RST, lo_eng: SCALE_LO_RST, hi_dac: SCALE_HI_RST, lo_dac: SCALE_LO_RST};

  typedef struct packed {
    logic outputs_enabled;
    logic backplane_ok;
    logic cpu_comm_ok;
    logic io_comm_ok;
    logic field_power_ok;
    logic hot_removed;
    logic service_request_call;
  } aods_pins_t;

  typedef struct packed {
    logic signed [31:0] eng;
    logic signed [31:0] dac;
    logic off_current;
    logic off_voltage;
  } aods_out_t;

  typedef struct packed {
    logic [25:0] zero;
    logic hot_hold;
    logic svc_hold;
    logic first_pending;
    logic reconfig;
    logic dirty;
    logic store;
  } aods_ctrl_t;
endpackage
`default_nettype wire

// >>> hdl/aods_ramp_step.sv
// One ramp step toward a target, clipped so it never overshoots
`default_nettype none
module aods_ramp_step
  import aods_pkg::*;
(
  input wire logic signed [31:0] cur,
  input wire logic signed [31:0] target,
  input wire logic signed [31:0] step,
  output logic signed [31:0] next_val
);
  logic signed [32:0] diff;
  logic signed [32:0] mag;
  logic signed [32:0] step_w;

  // Wide difference avoids wrap on full-scale swings
  always_comb begin
    diff = 33'(target) - 33'(cur);
    mag = (diff < 0) ? -diff : diff;
    step_w = 33'(step);
    if (step_w <= 0 || mag <= step_w) begin
      next_val = target;
    end else if (diff < 0) begin
      next_val = 32'(33'(cur) - step_w);
    end else begin
      next_val = 32'(33'(cur) + step_w);
    end
  end
endmodule // aods_ramp_step
`default_nettype wire

// >>> hdl/aods_scaler.sv
// Linear engineering-to-converter unit map through two scale point pairs
`default_nettype none
module aods_scaler
  import aods_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic signed [31:0] eng,
  input wire logic signed [31:0] hi_eng,
  input wire logic signed [31:0] lo_eng,
  input wire logic signed [31:0] hi_dac,
  input wire logic signed [31:0] lo_dac,
  input wire logic force_zero,
  output logic signed [31:0] dac_reg
);
  logic signed [32:0] d_eng;
  logic signed [32:0] span_eng;
  logic signed [32:0] span_dac;
  logic signed [65:0] prod;
  logic signed [65:0] quot;
  logic signed [31:0] dac_next;
  logic bypass;

  assign bypass = (hi_eng == hi_dac) && (lo_eng == lo_dac);

  // Q16.16 times Q16.16 over Q16.16 stays Q16.16; inverted spans work as signed
  always_comb begin
    d_eng = 33'(eng) - 33'(lo_eng);
    span_eng = 33'(hi_eng) - 33'(lo_eng);
    span_dac = 33'(hi_dac) - 33'(lo_dac);
    prod = 66'(d_eng) * 66'(span_dac);
    quot = '0;
    if (span_eng != 0) begin
      quot = prod / 66'(span_eng);
    end
    if (force_zero) begin
      dac_next = ZERO_VAL;
    end else if (bypass) begin
      dac_next = eng;
    end else begin
      dac_next = 32'(lo_dac + quot[31:0]);
    end
  end

  // Registered so the wide divide has a full cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dac_reg <= ZERO_VAL;
    end else begin
      dac_reg <= dac_next;
    end
  end

  a_scale_bypass: assert property (@(posedge clk) disable iff (!arst_n)
    bypass && !force_zero |=> dac_reg == $past(eng))
    else $error("bypassed scaling changed the value");
endmodule // aods_scaler
`default_nettype wire

// >>> sim/aods_cpu_model.sv
// Controller CPU side model: drives the backplane status pins
`default_nettype none
module aods_cpu_model
  import aods_pkg::*;
(
  input wire logic clk,
  input wire logic [2:0] mode,
  output var aods_pins_t pins
);
  // Mode bits: outputs enabled, backplane ok, field ok; comms stay up
  // Never raises the reset request, so no defaulting before it is owed
  always_ff @(posedge clk) begin
    pins <= '{outputs_enabled: mode[0], backplane_ok: mode[1], cpu_comm_ok: 1'b1, io_comm_ok: 1'b1,
      field_power_ok: mode[2], hot_removed: 1'b0, service_request_call: 1'b0};
  end
endmodule // aods_cpu_model
`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench for the output default and scaling block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import aods_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [2:0] mode = 3'h7;
  aods_pins_t pins;
  aods_out_t chan_out [NCH];
  int n_fail = 0;
  int check_count = 0;
  // Small update period keeps ramps short
  aods_top #(.UPDATE_CYCLES_P(8)) u_aods_top (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins_in(pins),
    .chan_out(chan_out));
  aods_cpu_model u_aods_cpu_model (.clk(clk), .mode(mode), .pins(pins));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, reset and watchdog
  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    #200000;
    n_fail++;
    conclude();
  end
  task automatic conclude();
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Pins pass model flop, two sync flops and the output flop
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [1:0] ch, input logic [3:0] idx, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= {ch, idx, 2'b00};
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_refused();
    chk({31'h0, chan_out[0].off_current}, 32'h1);
    rd(8'h3c, 32'h0000_0008);
    rd(8'h2c, 32'h0);
    rd(8'h01, 32'h0);
    $display("done: refused");
  endtask
  task automatic t_direct();
    wr(2'd0, IDX_CFG, 32'h2);
    wr(2'd0, IDX_CMD, 32'h0003_0000);
    waitc(4);
    chk(chan_out[0].eng, 32'h0003_0000);
    chk(chan_out[0].dac, 32'h0003_0000);
    $display("done: direct");
  endtask
  // Low points zero, below the high points
  task automatic t_scale();
    wr(2'd3, IDX_LO_ENG, 32'h0);
    wr(2'd3, IDX_LO_DAC, 32'h0);
    wr(2'd3, IDX_HI_ENG, 32'h0006_0000);
    wr(2'd3, IDX_HI_DAC, 32'h000c_0000);
    wr(2'd3, IDX_CFG, 32'h2);
    wr(2'd3, IDX_CMD, 32'h0003_0000);
    waitc(4);
    chk(chan_out[3].dac, 32'h0006_0000);
    wr(2'd3, IDX_LO_DAC, 32'h0002_0000);
    waitc(4);
    chk(chan_out[3].dac, 32'h0007_0000);
    $display("done: scale");
  endtask
  // Default lies inside the channel range
  task automatic t_default();
    wr(2'd1, IDX_CFG, 32'h6);
    wr(2'd1, IDX_CMD, 32'h0002_0000);
    wr(2'd0, IDX_DEF_VAL, 32'h0001_0000);
    mode <= 3'h6;
    waitc(6);
    chk(chan_out[0].eng, 32'h0001_0000);
    chk(chan_out[1].eng, 32'h0002_0000);
    mode <= 3'h5;
    wr(2'd0, IDX_DEF_RATE, 32'h0000_8000);
    waitc(5);
    chk(chan_out[0].eng, 32'h0001_0000);
    mode <= 3'h7;
    waitc(6);
    chk(chan_out[0].eng, 32'h0003_0000);
    $display("done: default");
  endtask
  task automatic t_ramp();
    int k;
    wr(2'd0, IDX_EN_RATE, 32'h0001_0000);
    wr(2'd0, IDX_CMD, 32'h0006_0000);
    for (k = 0; k < 40 && chan_out[0].eng === 32'h0003_0000; k++) waitc(1);
    chk(chan_out[0].eng, 32'h0004_0000);
    waitc(40);
    chk(chan_out[0].eng, 32'h0006_0000);
    $display("done: ramp");
  endtask
  // First store after power jumps to default; a later one ramps and holds the window open
  task automatic t_store();
    wr(2'd0, IDX_CTRL, 32'h1);
    waitc(1);
    chk(chan_out[0].eng, 32'h0001_0000);
    rd(8'h3c, 32'h0);
    waitc(20);
    wr(2'd0, IDX_CTRL, 32'h1);
    rd(8'h3c, 32'h0000_0004);
    $display("done: store");
  endtask
  task automatic t_field();
    wr(2'd2, IDX_CFG, 32'h0);
    waitc(3);
    chk({31'h0, chan_out[2].off_voltage}, 32'h1);
    mode <= 3'h3;
    waitc(6);
    chk(chan_out[1].eng, 32'h0);
    chk({31'h0, chan_out[0].off_current}, 32'h1);
    $display("done: field");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    waitc(6);
    t_refused();
    t_direct();
    t_scale();
    t_default();
    t_ramp();
    t_store();
    t_field();
    conclude();
  end
endmodule // tb
`default_nettype wire
